// ---- src/qspi_ctl_pkg.sv ----
// Package: register map, field positions, reset values and carrier types of the serial transfer control block
package qspi_ctl_pkg;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL_STATUS = 8'h00;
    localparam logic [7:0] OFS_CONFIG      = 8'h04;
    localparam logic [7:0] OFS_DATA_OUT    = 8'h08;
    localparam logic [7:0] OFS_DATA_IN     = 8'h0c;
    localparam logic [7:0] OFS_RD_COUNT    = 8'h20;

    // ------------------------------------------------------------
    // Control/status field positions
    // ------------------------------------------------------------
    localparam int BIT_TX_OVF   = 11;
    localparam int BIT_TX_UDF   = 10;
    localparam int BIT_RX_OVF   = 9;
    localparam int BIT_RX_UDF   = 8;
    localparam int BIT_TX_FULL  = 7;
    localparam int BIT_TX_EMPTY = 6;
    localparam int BIT_RX_FULL  = 5;
    localparam int BIT_RX_EMPTY = 4;
    localparam int BIT_XFER_RDY = 1;
    localparam int BIT_SEL_EN   = 0;

    // ------------------------------------------------------------
    // Configuration field positions and reset
    // ------------------------------------------------------------
    localparam int BIT_START    = 15;
    localparam int BIT_STOP     = 14;
    localparam int BIT_RW       = 13;
    localparam int BIT_UNIT     = 5;
    localparam int CONF_PLAIN_W = 13;
    localparam logic [CONF_PLAIN_W-1:0] CONF_PLAIN_RST = 13'h0002;

    // ------------------------------------------------------------
    // Queues and link timing
    // ------------------------------------------------------------
    localparam int QUEUE_W       = 8;
    localparam int QUEUE_DEPTH   = 8;
    localparam int UNIT_BYTES    = 4;
    localparam logic [1:0] PH_DRIVE  = 2'h0;
    localparam logic [1:0] PH_RISE   = 2'h2;
    localparam logic [1:0] PH_SAMPLE = 2'h3;
    localparam logic [2:0] LAST_BIT  = 3'h7;

    // Byte handed to the link domain, held stable while a request is pending
    typedef struct packed {
        logic               write;
        logic [QUEUE_W-1:0] data;
    } link_req_t;

    // Sticky queue error flags
    typedef struct packed {
        logic tx_ovf;
        logic tx_udf;
        logic rx_ovf;
        logic rx_udf;
    } queue_err_t;

endpackage

// ---- src/quad_serial_xfer_control.sv ----
// Serial flash transfer control: APB registers, byte queues and the serial shifter on the link clock
//
// Contract
// - Select output is low while select-enable is 1, high while it is 0.
// - Transfer-ready reads 0 during a transfer, 1 when idle and after reset.
// - Transmit queue full/empty flags at bits 7/6, reset 0 and 1.
// - Receive queue full/empty flags at bits 5/4, reset 0 and 1.
// - Transmit queue overflow/underflow sticky flags at bits 11/10, reset 0.
// - Receive queue overflow/underflow sticky flags at bits 9/8, reset 0.
// - Direction bit 13: 0 reads from the flash, 1 writes to it.
// - Start bit 15 launches a transfer, reads 1 while it runs, 0 after.
// - Read transfer clears start after the programmed read byte count.
// - Write transfer clears start once all queued data is shifted out; the code also waits for stop before clearing it.
// - Stop ends the transfer at the next 1-byte or 4-byte boundary; a write runs on while bytes are still queued.
// - At the boundary start clears first, stop clears one cycle later.
// - Unit bit selects 1 byte (0) or 4 bytes (1) per unit.
// - Read byte count register sits at offset 0x20.
//
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// Byte queue
// ------------------------------------------------------------
module byte_queue
    import qspi_ctl_pkg::*;
#(
    parameter int W     = QUEUE_W,
    parameter int DEPTH = QUEUE_DEPTH
)
(
    // Clock and reset
    input  wire logic         clk_in,
    input  wire logic         rst_n_in,
    // Fill side
    input  wire logic         push_in,
    input  wire logic [W-1:0] data_in,
    // Drain side
    input  wire logic         pop_in,
    output logic [W-1:0]      data_out,
    // Status
    output logic              full_out,
    output logic              empty_out
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem [DEPTH];
    logic [AW:0]  wr_ptr;
    logic [AW:0]  rd_ptr;

    wire do_push = push_in && !full_out;
    wire do_pop  = pop_in && !empty_out;

    assign full_out  = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
    assign empty_out = (wr_ptr == rd_ptr);
    assign data_out  = mem[rd_ptr[AW-1:0]];

    always_ff @(posedge clk_in)
    begin
        if (do_push)
            mem[wr_ptr[AW-1:0]] <= data_in;
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end
        else
        begin
            wr_ptr <= wr_ptr + (AW+1)'(do_push);
            rd_ptr <= rd_ptr + (AW+1)'(do_pop);
        end
    end
endmodule

// ------------------------------------------------------------
// Top level
// ------------------------------------------------------------
module quad_serial_xfer_control
    import qspi_ctl_pkg::*;
(
    // System clock and reset
    input  wire logic        sys_clk_in,
    input  wire logic        rst_n_in,
    // APB slave
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [7:0]  paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic [31:0]      prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    // Link clock
    input  wire logic        link_clk_in,
    // Serial flash pins
    output logic             sclk_out,
    output logic             sel_n_out,
    input  wire logic [3:0]  io_in,
    output logic [3:0]       io_out,
    output logic [3:0]       io_oe_out
);
    // ------------------------------------------------------------
    // Registers and state
    // ------------------------------------------------------------
    typedef enum logic [2:0] {ST_IDLE, ST_FETCH, ST_WAIT, ST_END_START, ST_END_STOP} xfer_state_t;

    xfer_state_t            state;
    logic                   sel_en;
    logic                   start;
    logic                   stop;
    logic                   rw_write;
    logic [CONF_PLAIN_W-1:0] conf_plain;
    logic [31:0]            rd_count;
    logic [31:0]            byte_cnt;
    logic [1:0]             unit_cnt;
    queue_err_t             err;
    link_req_t              hold;
    logic                   req_tgl;
    logic                   ack_s1;
    logic                   ack_s2;
    logic                   ack_s3;

    // Link domain
    logic                   lrst_s1;
    logic                   lrst_n;
    logic                   req_s1;
    logic                   req_s2;
    logic                   ack_tgl;
    logic                   busy;
    logic                   busy_write;
    logic [1:0]             phase;
    logic [2:0]             bit_cnt;
    logic [QUEUE_W-1:0]     shift;
    logic [QUEUE_W-1:0]     rx_byte;
    logic                   miso_s1;
    logic                   miso_s2;

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    wire setup    = psel_in && !penable_in;
    wire access   = psel_in && penable_in;
    wire wr_acc   = access && pwrite_in;
    wire rd_acc   = access && !pwrite_in;
    wire hit_ctrl = (paddr_in == OFS_CTRL_STATUS);
    wire hit_conf = (paddr_in == OFS_CONFIG);
    wire hit_dout = (paddr_in == OFS_DATA_OUT);
    wire hit_din  = (paddr_in == OFS_DATA_IN);
    wire hit_cnt  = (paddr_in == OFS_RD_COUNT);
    wire mapped   = hit_ctrl || hit_conf || hit_dout || hit_din || hit_cnt;
    wire wr_ctrl  = wr_acc && hit_ctrl;
    wire wr_conf  = wr_acc && hit_conf;
    wire wr_dout  = wr_acc && hit_dout;
    wire wr_cnt   = wr_acc && hit_cnt;
    wire rd_din   = rd_acc && hit_din;

    assign pready_out = access;

    // ------------------------------------------------------------
    // Queues
    // ------------------------------------------------------------
    logic [QUEUE_W-1:0] tx_head;
    logic [QUEUE_W-1:0] rx_head;
    logic               tx_full;
    logic               tx_empty;
    logic               rx_full;
    logic               rx_empty;

    wire pending  = (req_tgl != ack_s2);
    wire ack_evt  = (ack_s2 != ack_s3);
    wire tx_pop   = (state == ST_FETCH) && rw_write && !tx_empty && !(stop && unit_cnt == 2'h0 && tx_empty);
    wire rx_push  = ack_evt && !hold.write;

    byte_queue u_tx_queue (
        .clk_in    (sys_clk_in),
        .rst_n_in  (rst_n_in),
        .push_in   (wr_dout),
        .data_in   (pwdata_in[QUEUE_W-1:0]),
        .pop_in    (tx_pop),
        .data_out  (tx_head),
        .full_out  (tx_full),
        .empty_out (tx_empty)
    );

    byte_queue u_rx_queue (
        .clk_in    (sys_clk_in),
        .rst_n_in  (rst_n_in),
        .push_in   (rx_push),
        .data_in   (rx_byte),
        .pop_in    (rd_din),
        .data_out  (rx_head),
        .full_out  (rx_full),
        .empty_out (rx_empty)
    );

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    wire xfer_rdy = (state == ST_IDLE) && !start;

    wire [31:0] ctrl_word = {20'h00000,
                             err.tx_ovf, err.tx_udf, err.rx_ovf, err.rx_udf,
                             tx_full, tx_empty,
                             rx_full, rx_empty,
                             2'h0, xfer_rdy, sel_en};
    wire [31:0] conf_word = {16'h0000, start, stop, rw_write, conf_plain};
    wire [31:0] rd_mux    = hit_ctrl ? ctrl_word :
                            hit_conf ? conf_word :
                            hit_din  ? {24'h000000, rx_head} :
                            hit_cnt  ? rd_count : 32'h00000000;

    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            prdata_out  <= 32'h00000000;
            pslverr_out <= 1'b0;
        end
        else if (setup)
        begin
            prdata_out  <= pwrite_in ? 32'h00000000 : rd_mux;
            pslverr_out <= !mapped;
        end
    end

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    wire unit_done = !conf_plain[BIT_UNIT] || (unit_cnt == 2'(UNIT_BYTES - 1));
    wire launch    = wr_conf && pwdata_in[BIT_START] && !start;
    wire clr_start = (state == ST_END_START);
    wire clr_stop  = (state == ST_END_STOP);

    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            sel_en     <= 1'b0;
            start      <= 1'b0;
            stop       <= 1'b0;
            rw_write   <= 1'b0;
            conf_plain <= CONF_PLAIN_RST;
            rd_count   <= 32'h00000000;
            sel_n_out  <= 1'b1;
        end
        else
        begin
            sel_n_out <= !sel_en;
            if (wr_ctrl)
                sel_en <= pwdata_in[BIT_SEL_EN];
            if (wr_cnt)
                rd_count <= pwdata_in;
            if (clr_start)
                start <= 1'b0;
            else if (wr_conf)
                start <= pwdata_in[BIT_START] || start;
            if (clr_stop)
                stop <= 1'b0;
            else if (wr_conf && !clr_start)
                stop <= pwdata_in[BIT_STOP];
            if (wr_conf && xfer_rdy)
            begin
                rw_write   <= pwdata_in[BIT_RW];
                conf_plain <= pwdata_in[CONF_PLAIN_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Sticky queue errors; cleared by launching a transfer, set wins
    // ------------------------------------------------------------
    wire tx_udf_evt = (state == ST_FETCH) && rw_write && tx_empty && (unit_cnt != 2'h0);

    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            err <= '0;
        else
        begin
            err.tx_ovf <= (wr_dout && tx_full) || (err.tx_ovf && !launch);
            err.tx_udf <= tx_udf_evt || (err.tx_udf && !launch);
            err.rx_ovf <= (rx_push && rx_full) || (err.rx_ovf && !launch);
            err.rx_udf <= (rd_din && rx_empty) || (err.rx_udf && !launch);
        end
    end

    // ------------------------------------------------------------
    // Transfer sequencer
    // ------------------------------------------------------------
    wire read_done = !hold.write && (rd_count != 32'h00000000) && (byte_cnt + 32'h1 == rd_count);
    wire stop_end  = stop && unit_done;

    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            state    <= ST_IDLE;
            byte_cnt <= 32'h00000000;
            unit_cnt <= 2'h0;
            hold     <= '0;
            req_tgl  <= 1'b0;
        end
        else
        begin
            unique case (state)
                ST_IDLE:
                begin
                    byte_cnt <= 32'h00000000;
                    unit_cnt <= 2'h0;
                    if (start)
                        state <= ST_FETCH;
                end
                ST_FETCH:
                begin
                    if (!rw_write)
                    begin
                        hold    <= '{write: 1'b0, data: '0};
                        req_tgl <= !req_tgl;
                        state   <= ST_WAIT;
                    end
                    else if (!tx_empty)
                    begin
                        hold    <= '{write: 1'b1, data: tx_head};
                        req_tgl <= !req_tgl;
                        state   <= ST_WAIT;
                    end
                    else if (stop && unit_cnt == 2'h0)
                        state <= ST_END_START;
                end
                ST_WAIT:
                begin
                    if (ack_evt)
                    begin
                        byte_cnt <= byte_cnt + 32'h1;
                        unit_cnt <= conf_plain[BIT_UNIT] ? unit_cnt + 2'h1 : 2'h0;
                        // A write with bytes still queued runs on until a boundary where the queue is empty
                        if (read_done || (stop_end && (!hold.write || tx_empty)))
                            state <= ST_END_START;
                        else
                            state <= ST_FETCH;
                    end
                end
                ST_END_START:
                    state <= ST_END_STOP;
                ST_END_STOP:
                    state <= ST_IDLE;
            endcase
        end
    end

    // Acknowledge toggle back from the link clock
    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            ack_s1 <= 1'b0;
            ack_s2 <= 1'b0;
            ack_s3 <= 1'b0;
        end
        else
        begin
            ack_s1 <= ack_tgl;
            ack_s2 <= ack_s1;
            ack_s3 <= ack_s2;
        end
    end

    // ------------------------------------------------------------
    // Link domain: reset release, request and data input sync
    // ------------------------------------------------------------
    always_ff @(posedge link_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            lrst_s1 <= 1'b0;
            lrst_n  <= 1'b0;
        end
        else
        begin
            lrst_s1 <= 1'b1;
            lrst_n  <= lrst_s1;
        end
    end

    always_ff @(posedge link_clk_in or negedge lrst_n)
    begin
        if (!lrst_n)
        begin
            req_s1  <= 1'b0;
            req_s2  <= 1'b0;
            miso_s1 <= 1'b0;
            miso_s2 <= 1'b0;
        end
        else
        begin
            req_s1  <= req_tgl;
            req_s2  <= req_s1;
            miso_s1 <= io_in[1];
            miso_s2 <= miso_s1;
        end
    end

    // ------------------------------------------------------------
    // Link domain: byte shifter, mode 0, four link clocks per bit
    // ------------------------------------------------------------
    // The synced input lags two link clocks, so each bit is sampled at the
    // first phase where the flash's data is certain to have settled.
    wire new_req = !busy && (req_s2 != ack_tgl);

    always_ff @(posedge link_clk_in or negedge lrst_n)
    begin
        if (!lrst_n)
        begin
            busy       <= 1'b0;
            busy_write <= 1'b0;
            phase      <= 2'h0;
            bit_cnt    <= 3'h0;
            shift      <= '0;
            rx_byte    <= '0;
            ack_tgl    <= 1'b0;
            sclk_out   <= 1'b0;
            io_out     <= 4'h0;
            io_oe_out  <= 4'h0;
        end
        else if (new_req)
        begin
            busy       <= 1'b1;
            busy_write <= hold.write;
            shift      <= hold.data;
            phase      <= 2'h0;
            bit_cnt    <= 3'h0;
        end
        else if (busy)
        begin
            phase <= phase + 2'h1;
            if (phase == PH_DRIVE)
            begin
                sclk_out     <= 1'b0;
                io_out[0]    <= shift[QUEUE_W-1];
                io_oe_out[0] <= busy_write;
            end
            if (phase == PH_RISE)
                sclk_out <= 1'b1;
            if (phase == PH_SAMPLE)
            begin
                shift   <= {shift[QUEUE_W-2:0], miso_s2};
                bit_cnt <= bit_cnt + 3'h1;
                if (bit_cnt == LAST_BIT)
                begin
                    busy    <= 1'b0;
                    rx_byte <= {shift[QUEUE_W-2:0], miso_s2};
                    ack_tgl <= !ack_tgl;
                end
            end
        end
        else
        begin
            sclk_out  <= 1'b0;
            io_oe_out <= 4'h0;
        end
    end

endmodule

`default_nettype wire

// ---- testbench/quad_serial_xfer_control_asserts.sv ----
// Checker: port-level assertions for the serial transfer control block
`timescale 1ns/1ps
`default_nettype none
module quad_serial_xfer_control_asserts
    import qspi_ctl_pkg::*;
(
    // Clocks and reset
    input wire logic        sys_clk_in,
    input wire logic        rst_n_in,
    input wire logic        link_clk_in,
    // APB slave
    input wire logic        psel_in,
    input wire logic        penable_in,
    input wire logic        pwrite_in,
    input wire logic [7:0]  paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [31:0] prdata_out,
    input wire logic        pready_out,
    input wire logic        pslverr_out,
    // Serial pins
    input wire logic        sclk_out,
    input wire logic        sel_n_out,
    input wire logic [3:0]  io_in,
    input wire logic [3:0]  io_out,
    input wire logic [3:0]  io_oe_out
);
    wire logic acc    = psel_in && penable_in;
    wire logic rd_acc = acc && !pwrite_in;
    wire logic ctl_rd = rd_acc && paddr_in == OFS_CTRL_STATUS;
    wire logic ctl_wr = acc && pwrite_in && paddr_in == OFS_CTRL_STATUS;
    wire logic mapped = paddr_in inside {OFS_CTRL_STATUS, OFS_CONFIG, OFS_DATA_OUT, OFS_DATA_IN, OFS_RD_COUNT};

    sel_follow_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        ctl_wr |-> ##2 sel_n_out == !$past(pwdata_in[0], 2))
        else $error("select output does not follow its enable bit");
    sel_hold_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        !$stable(sel_n_out) |-> $past(ctl_wr) || $past(ctl_wr, 2))
        else $error("select output moved without a control write");
    sclk_high_a: assert property (@(posedge link_clk_in) disable iff (!rst_n_in)
        $rose(sclk_out) |=> sclk_out ##1 !sclk_out)
        else $error("serial clock high phase has the wrong length");
    sclk_low_a: assert property (@(posedge link_clk_in) disable iff (!rst_n_in)
        $fell(sclk_out) |=> !sclk_out)
        else $error("serial clock low phase too short");
    io_stable_a: assert property (@(posedge link_clk_in) disable iff (!rst_n_in)
        sclk_out && $past(sclk_out) |-> $stable(io_out[0]))
        else $error("data pin changed while serial clock high");
    addr_err_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        acc |-> pslverr_out == !mapped)
        else $error("error response does not match address decode");
    conf_rsvd_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        rd_acc && paddr_in == OFS_CONFIG |-> prdata_out[31:16] == 16'h0)
        else $error("configuration upper half reads nonzero");
    tx_flags_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        ctl_rd |-> !(prdata_out[7] && prdata_out[6]))
        else $error("transmit queue both full and empty");
    rx_flags_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        ctl_rd |-> !(prdata_out[5] && prdata_out[4]))
        else $error("receive queue both full and empty");
endmodule

bind quad_serial_xfer_control quad_serial_xfer_control_asserts chk (
    .sys_clk_in, .rst_n_in, .link_clk_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
    .prdata_out, .pready_out, .pslverr_out, .sclk_out, .sel_n_out, .io_in, .io_out, .io_oe_out
);
`default_nettype wire

// ---- testbench/flash_model.sv ----
// Flash model: single-pin serial memory streaming a counting pattern and recording written bytes
`timescale 1ns/1ps
`default_nettype none
module flash_model (
    // Pins from the controller
    input  wire logic       sclk_in,
    input  wire logic       sel_n_in,
    input  wire logic       mosi_in,
    // Pins back and captured byte
    output logic      [3:0] io_out,
    output logic      [7:0] got_out
);
    logic [10:0] pos = 11'h0;
    logic [7:0]  sh  = 8'h0;
    logic [7:0]  cur;
    logic        q   = 1'b0;

    // Spare pins sit on pull-ups; a deselected data pin shows the inverse of its last bit
    assign cur    = 8'h5a + pos[10:3];
    assign io_out = {2'b11, q ^ sel_n_in, 1'b1};

    // Select falling restarts the pattern; sclk is low then
    always @(posedge sclk_in or negedge sel_n_in)
    begin
        if (!sclk_in)
            pos = 11'h0;
        else
        begin
            sh  = {sh[6:0], mosi_in};
            pos = pos + 11'h1;
            if (pos[2:0] == 3'h0)
                got_out = sh;
        end
    end

    // Mode 0: next bit goes out on the falling edge, held through the next rise
    always @(negedge sclk_in or negedge sel_n_in)
        q = cur[~pos[2:0]];
endmodule
`default_nettype wire

// ---- testbench/quad_serial_xfer_control_test.sv ----
// Testbench: APB-driven checks of the serial transfer control block against a flash model
`timescale 1ns/1ps
`default_nettype none
module quad_serial_xfer_control_test;
    import qspi_ctl_pkg::*;
    logic        sys_clk = 1'b0;
    logic        link_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic [31:0] r;
    logic        pready;
    logic        pslverr;
    logic        err;
    logic        sclk;
    logic        sel_n;
    logic [3:0]  io_in;
    logic [3:0]  io_out;
    logic [3:0]  io_oe;
    logic [7:0]  got;
    int          bad_count = 0;
    int          checked = 0;
    int          cycles = 0;
    int          i;

    quad_serial_xfer_control DUT (.sys_clk_in(sys_clk), .rst_n_in(rst_n), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .link_clk_in(link_clk),
        .sclk_out(sclk), .sel_n_out(sel_n), .io_in(io_in), .io_out(io_out), .io_oe_out(io_oe));
    flash_model flash (.sclk_in(sclk), .sel_n_in(sel_n), .mosi_in(io_oe[0] ? io_out[0] : 1'b1),
        .io_out(io_in), .got_out(got));

    initial forever #4 sys_clk = ~sys_clk;
    initial
    begin
        #1;
        forever #6 link_clk = ~link_clk;
    end

    task automatic stop_test;
        if (bad_count == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1)
            @(posedge sys_clk);
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        check(r & m, e);
    endtask

    // Unbounded poll; with ord set it also watches the start/stop clearing order
    task automatic poll(input logic [7:0] a, input int b, input logic v, input logic ord);
        apb(1'b0, a, 32'h0);
        while (r[b] !== v)
        begin
            if (ord)
                check(32'(r[15:14] == 2'b10), 32'h0);
            apb(1'b0, a, 32'h0);
        end
    endtask

    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            bad_count++;
            stop_test();
        end
    end

    initial
    begin
        // Held long enough for two link-clock rising edges as well
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        rd(OFS_CTRL_STATUS, 32'h0000_0ff3, 32'h0000_0052);
        rd(OFS_CONFIG, 32'hffff_ffff, 32'h0000_0002);
        rd(OFS_RD_COUNT, 32'hffff_ffff, 32'h0);
        apb(1'b0, 8'h10, 32'h0);
        check(r, 32'h0);
        check(32'(err), 32'h1);
        wr(OFS_CTRL_STATUS, 32'h1);
        repeat (2) @(posedge sys_clk);
        check(32'(sel_n), 32'h0);
        // Nine bytes into an eight-deep receive queue
        wr(OFS_RD_COUNT, 32'd9);
        rd(OFS_RD_COUNT, 32'hffff_ffff, 32'd9);
        wr(OFS_CONFIG, 32'h0000_8002);
        rd(OFS_CTRL_STATUS, 32'h2, 32'h0);
        rd(OFS_CONFIG, 32'h8000, 32'h8000);
        poll(OFS_CONFIG, 15, 1'b0, 1'b0);
        rd(OFS_CTRL_STATUS, 32'hff3, 32'h263);
        check(32'(sclk), 32'h0);
        for (i = 0; i < 8; i++)
            rd(OFS_DATA_IN, 32'hff, 32'h5a + i);
        rd(OFS_DATA_IN, 32'h0, 32'h0);
        rd(OFS_CTRL_STATUS, 32'h330, 32'h310);
        // Write with one-byte units, queue overfilled first
        for (i = 0; i < 9; i++)
            wr(OFS_DATA_OUT, 32'h30 + i);
        rd(OFS_CTRL_STATUS, 32'hcc0, 32'h880);
        wr(OFS_CONFIG, 32'h0000_a002);
        poll(OFS_CTRL_STATUS, 6, 1'b1, 1'b0);
        wr(OFS_CONFIG, 32'h0000_e002);
        poll(OFS_CONFIG, 15, 1'b0, 1'b1);
        rd(OFS_CONFIG, 32'hc000, 32'h0);
        check(32'(got), 32'h37);
        rd(OFS_CTRL_STATUS, 32'h2, 32'h2);
        // Four-byte units: stop must wait for the unit to complete
        wr(OFS_CONFIG, 32'h0000_0022);
        rd(OFS_CONFIG, 32'hffff, 32'h0022);
        wr(OFS_CONFIG, 32'h0000_a022);
        wr(OFS_DATA_OUT, 32'hc1);
        wr(OFS_DATA_OUT, 32'hc2);
        poll(OFS_CTRL_STATUS, 6, 1'b1, 1'b0);
        wr(OFS_CONFIG, 32'h0000_e022);
        repeat (300) @(posedge sys_clk);
        rd(OFS_CONFIG, 32'h8000, 32'h8000);
        rd(OFS_CTRL_STATUS, 32'h400, 32'h400);
        wr(OFS_DATA_OUT, 32'hc3);
        wr(OFS_DATA_OUT, 32'hc4);
        poll(OFS_CONFIG, 15, 1'b0, 1'b1);
        check(32'(got), 32'hc4);
        wr(OFS_CTRL_STATUS, 32'h0);
        repeat (2) @(posedge sys_clk);
        check(32'(sel_n), 32'h1);
        stop_test();
    end
endmodule
`default_nettype wire
